/* File: lpjc_top.sv */
`timescale 1ns/1ps
module lpjc_top #(
  parameter int unsigned MS_CYCLES =
    lpjc_pkg::CLK_HZ / lpjc_pkg::MS_PER_S
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic join_start,
  input wire logic join_ok,
  input wire logic join_fail,
  output logic join_req,
  output logic [3:0] join_sf,
  output logic join_busy,
  output logic joined,
  output logic otaa_mode,
  output logic rx_win_eff,
  output logic adr_en,
  output logic duty_en,
  output logic adapt_chan_en,
  output logic adapt_rx2_en,
  output logic rx2_def_sf9,
  output logic private_net,
  output logic confirmed_sel,
  output logic [3:0] repeat_cnt,
  output logic repeat_default,
  output logic [7:0] frame_port,
  output logic port_mac_only,
  output logic port_remote,
  output logic port_test,
  output logic port_reserved,
  output logic fixed_dr_apply,
  output logic fixed_rx2_apply
);
  import lpjc_pkg::*;

  // ---------------------------------------------------------------
  // Derived time counts
  // ---------------------------------------------------------------
  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);
  localparam logic [31:0] PAUSE_MIN_MS =
    32'(PAUSE_MIN_MIN * S_PER_MIN * MS_PER_S);
  localparam logic [31:0] RAND_MAX_MS = 32'(RAND_MAX_S * MS_PER_S);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [7:0] emis;
    logic [7:0] port;
    logic [7:0] behav;
    logic [7:0] join_cfg;
    logic [7:0] rdata;
    lpjc_state_t st;
    logic [2:0] sf_idx;
    logic [3:0] tries;
    logic [16:0] ms_cnt;
    logic [31:0] wait_ms;
    logic req;
    logic joined;
    logic rx_win;
    logic conf_sel;
    logic [3:0] rep_cnt;
    logic rep_def;
    logic [3:0] sf;
    logic p_mac;
    logic p_remote;
    logic p_test;
    logic p_resv;
    logic fix_dr;
    logic fix_rx2;
  } lpjc_regs_t;

  localparam lpjc_regs_t RST_Q = '{
    rst_s1: 1'b0,
    rst_s2: 1'b0,
    emis: EMIS_RST,
    port: PORT_RST,
    behav: BEHAV_RST,
    join_cfg: JOIN_RST,
    rdata: 8'h00,
    st: ST_IDLE,
    sf_idx: 3'd0,
    tries: 4'h0,
    ms_cnt: 17'h00000,
    wait_ms: 32'h00000000,
    req: 1'b0,
    joined: 1'b0,
    rx_win: 1'b0,
    conf_sel: 1'b0,
    rep_cnt: 4'h0,
    rep_def: 1'b1,
    sf: 4'(SF_BASE),
    p_mac: 1'b0,
    p_remote: 1'b0,
    p_test: 1'b0,
    p_resv: 1'b0,
    fix_dr: 1'b1,
    fix_rx2: 1'b1
  };

  lpjc_regs_t q_ff;
  lpjc_regs_t nxt_q;
  logic [31:0] rnd;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Factors in use: SF7 and SF12 always, the four middle ones by enable.
  function automatic logic [5:0] sf_mask(input logic [7:0] jc);
    sf_mask = {1'b1, jc[JOIN_SFEN_LSB +: 4], 1'b1};
  endfunction : sf_mask

  // Next enabled factor above idx; SF12 is always enabled so one exists.
  function automatic logic [2:0] next_sf(input logic [2:0] idx,
                                         input logic [5:0] m);
    logic [2:0] r;
    r = SF_LAST_IDX;
    for (int i = 5; i >= 1; i--) begin
      if (3'(i) > idx && m[i]) begin
        r = 3'(i);
      end
    end
    next_sf = r;
  endfunction : next_sf

  function automatic logic [31:0] fixed_ms(input logic [2:0] idx);
    int unsigned s;
    unique case (idx)
      3'd0: s = WAIT_SF7_S;
      3'd1: s = WAIT_SF8_S;
      3'd2: s = WAIT_SF9_S;
      3'd3: s = WAIT_SF10_S;
      3'd4: s = WAIT_SF11_S;
      default: s = WAIT_SF12_S;
    endcase
    fixed_ms = 32'(s * MS_PER_S);
  endfunction : fixed_ms

  function automatic logic [3:0] tries_per_sf(input logic [7:0] jc);
    if (jc[JOIN_TRIES_LSB +: 4] == 4'h0) begin
      tries_per_sf = 4'(DEF_TRIES);
    end else begin
      tries_per_sf = jc[JOIN_TRIES_LSB +: 4];
    end
  endfunction : tries_per_sf

  function automatic logic [3:0] conf_of(input logic [7:0] e);
    conf_of = e[EMIS_CONF_LSB +: 4];
  endfunction : conf_of

  function automatic logic [3:0] unc_of(input logic [7:0] e);
    unc_of = e[EMIS_UNC_LSB +: 4];
  endfunction : unc_of

  // ---------------------------------------------------------------
  // Random source
  // ---------------------------------------------------------------
  lpjc_lfsr u_lfsr (
    .clk_sys(clk_sys),
    .rst_n(q_ff.rst_s2),
    .rnd(rnd)
  );

  logic [18:0] rand_prod;
  logic [31:0] rand_ms;
  logic [31:0] pause_ms;
  logic [31:0] step_wait;
  logic ms_tick;
  logic [5:0] mask;

  always_comb begin
    // Scale 12 random bits onto 0 .. 3999 ms.
    rand_prod = 19'(rnd[11:0]) * 19'd125;
    rand_ms = {20'h00000, rand_prod[18:7]};
    if (rand_ms > RAND_MAX_MS) begin
      rand_ms = RAND_MAX_MS;
    end
    // Two random terms keep the pause inside its twenty minute band.
    pause_ms = PAUSE_MIN_MS + {12'h000, rnd[31:12]}
             + {15'h0000, rnd[16:0]};
    step_wait = fixed_ms(q_ff.sf_idx) + rand_ms;
    ms_tick = (q_ff.ms_cnt == MS_LAST);
    mask = sf_mask(q_ff.join_cfg);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.rst_s1 = 1'b1;
    nxt_q.rst_s2 = q_ff.rst_s1;
    nxt_q.req = 1'b0;

    // Register writes from the command decoder.
    if (cfg_wr) begin
      unique case (cfg_addr)
        REG_EMIS_IDX: nxt_q.emis = cfg_wdata;
        REG_PORT_IDX: nxt_q.port = cfg_wdata;
        REG_BEHAV_IDX: nxt_q.behav = cfg_wdata;
        REG_JOIN_IDX: nxt_q.join_cfg = cfg_wdata;
        default: nxt_q.emis = q_ff.emis;
      endcase
    end

    unique case (cfg_addr)
      REG_EMIS_IDX: nxt_q.rdata = q_ff.emis;
      REG_PORT_IDX: nxt_q.rdata = q_ff.port;
      REG_BEHAV_IDX: nxt_q.rdata = q_ff.behav;
      REG_JOIN_IDX: nxt_q.rdata = q_ff.join_cfg;
      REG_STAT_IDX: nxt_q.rdata = {q_ff.joined, q_ff.sf_idx,
                                   1'b0, q_ff.st};
      default: nxt_q.rdata = 8'h00;
    endcase

    // Millisecond base runs only while waiting.
    if (q_ff.st == ST_WAIT || q_ff.st == ST_PAUSE) begin
      nxt_q.ms_cnt = ms_tick ? 17'h00000 : q_ff.ms_cnt + 17'h00001;
    end else begin
      nxt_q.ms_cnt = 17'h00000;
    end

    unique case (q_ff.st)
      ST_IDLE, ST_JOINED: begin
        if (join_start) begin
          if (q_ff.behav[BEH_OTAA]) begin
            nxt_q.joined = 1'b0;
            nxt_q.sf_idx = 3'd0;
            nxt_q.tries = 4'h0;
            nxt_q.st = ST_SEND;
          end else begin
            // Personalization needs no over-the-air exchange.
            nxt_q.joined = 1'b1;
            nxt_q.st = ST_JOINED;
          end
        end
      end
      ST_SEND: begin
        nxt_q.req = 1'b1;
        nxt_q.st = ST_RESULT;
      end
      ST_RESULT: begin
        if (join_ok) begin
          nxt_q.joined = 1'b1;
          nxt_q.st = ST_JOINED;
        end else if (join_fail) begin
          if (q_ff.tries + 4'h1 < tries_per_sf(q_ff.join_cfg)) begin
            nxt_q.tries = q_ff.tries + 4'h1;
            nxt_q.wait_ms = step_wait;
            nxt_q.st = ST_WAIT;
          end else if (q_ff.sf_idx == SF_LAST_IDX) begin
            nxt_q.tries = 4'h0;
            nxt_q.sf_idx = 3'd0;
            nxt_q.wait_ms = pause_ms;
            nxt_q.st = ST_PAUSE;
          end else begin
            nxt_q.tries = 4'h0;
            nxt_q.sf_idx = next_sf(q_ff.sf_idx, mask);
            nxt_q.wait_ms = step_wait;
            nxt_q.st = ST_WAIT;
          end
        end
      end
      ST_WAIT, ST_PAUSE: begin
        if (join_ok) begin
          nxt_q.joined = 1'b1;
          nxt_q.st = ST_JOINED;
        end else if (q_ff.wait_ms == 32'h00000000) begin
          nxt_q.st = ST_SEND;
        end else if (ms_tick) begin
          nxt_q.wait_ms = q_ff.wait_ms - 32'h00000001;
        end
      end
      default: begin
        nxt_q.st = ST_IDLE;
      end
    endcase

    // The synchronised reset clears everything but the synchroniser.
    if (!q_ff.rst_s2) begin
      nxt_q = RST_Q;
      nxt_q.rst_s1 = 1'b1;
      nxt_q.rst_s2 = q_ff.rst_s1;
    end

    // Decoded outputs are registered with the registers that feed them,
    // so each one settles on the same edge as its source.
    nxt_q.conf_sel = (conf_of(nxt_q.emis) != 4'h0);
    nxt_q.rx_win = nxt_q.behav[BEH_RXWIN]
                 | nxt_q.behav[BEH_ADR]
                 | nxt_q.conf_sel;
    nxt_q.rep_cnt = nxt_q.conf_sel ? conf_of(nxt_q.emis)
                                   : unc_of(nxt_q.emis);
    nxt_q.rep_def = (conf_of(nxt_q.emis) == 4'h0)
                  && (unc_of(nxt_q.emis) == 4'h0);
    nxt_q.sf = 4'(SF_BASE) + {1'b0, nxt_q.sf_idx};
    nxt_q.p_mac = (nxt_q.port == PORT_MAC);
    nxt_q.p_remote = (nxt_q.port == PORT_REMOTE);
    nxt_q.p_test = (nxt_q.port == PORT_TEST);
    nxt_q.p_resv = (nxt_q.port > PORT_TEST);
    nxt_q.fix_dr = ~nxt_q.behav[BEH_ADR];
    nxt_q.fix_rx2 = ~nxt_q.behav[BEH_ADRX2];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_ff <= RST_Q;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg_rdata = q_ff.rdata;
  assign join_req = q_ff.req;
  assign join_sf = q_ff.sf;
  assign join_busy = (q_ff.st != ST_IDLE) && (q_ff.st != ST_JOINED);
  assign joined = q_ff.joined;
  assign otaa_mode = q_ff.behav[BEH_OTAA];
  assign adr_en = q_ff.behav[BEH_ADR];
  assign duty_en = q_ff.behav[BEH_DUTY];
  assign adapt_chan_en = q_ff.behav[BEH_ADCH];
  assign adapt_rx2_en = q_ff.behav[BEH_ADRX2];
  assign rx2_def_sf9 = q_ff.behav[BEH_RX2SF9];
  assign private_net = q_ff.behav[BEH_PRIV];
  assign rx_win_eff = q_ff.rx_win;
  assign confirmed_sel = q_ff.conf_sel;
  assign repeat_cnt = q_ff.rep_cnt;
  assign repeat_default = q_ff.rep_def;
  assign frame_port = q_ff.port;
  assign port_mac_only = q_ff.p_mac;
  assign port_remote = q_ff.p_remote;
  assign port_test = q_ff.p_test;
  assign port_reserved = q_ff.p_resv;
  assign fixed_dr_apply = q_ff.fix_dr;
  assign fixed_rx2_apply = q_ff.fix_rx2;

endmodule : lpjc_top

/* File: lpjc_pkg.sv */
// Notes on behaviour
// - Confirmed frames force receive windows on.
// - Nonzero confirmed count overrides unconfirmed setting.
// - Emission bits 0:3 give unconfirmed repeat count.
// - Emission bits 4:7 give confirmed attempt limit.
// - Port register selects frame port and class.
// - Behaviour bit 0 selects over-the-air join.
// - Behaviour bits 1..5 are single feature enables.
// - Behaviour bit 6 picks second window default.
// - Behaviour bit 7 selects private network settings.
// - Join bits 0:3 give tries, zero means four.
// - Join bits 4..7 enable SF8 to SF11.
// - SF7 and SF12 are always in the cycle.
// - Finish one factor's tries, then step upward.
// - Wait per last factor plus random four seconds.
// - Pause fifty to seventy minutes between cycles.
// - Failed attempt continues the current cycle.
// - Successful join stops the cycle at once.
// - Fixed factor and power only without adaptive rate.
// - Fixed second-window factor only without adaptation.
package lpjc_pkg;

  // ---------------------------------------------------------------
  // Register indices and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_EMIS_IDX = 8'h50;
  localparam logic [7:0] REG_PORT_IDX = 8'h52;
  localparam logic [7:0] REG_BEHAV_IDX = 8'h53;
  localparam logic [7:0] REG_JOIN_IDX = 8'h56;
  localparam logic [7:0] REG_STAT_IDX = 8'h57;
  localparam logic [7:0] EMIS_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h01;
  localparam logic [7:0] BEHAV_RST = 8'h00;
  localparam logic [7:0] JOIN_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EMIS_UNC_LSB = 0;
  localparam int EMIS_CONF_LSB = 4;
  localparam int BEH_OTAA = 0;
  localparam int BEH_RXWIN = 1;
  localparam int BEH_ADR = 2;
  localparam int BEH_DUTY = 3;
  localparam int BEH_ADCH = 4;
  localparam int BEH_ADRX2 = 5;
  localparam int BEH_RX2SF9 = 6;
  localparam int BEH_PRIV = 7;
  localparam int JOIN_TRIES_LSB = 0;
  localparam int JOIN_SFEN_LSB = 4;

  // ---------------------------------------------------------------
  // Port values
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_MAC = 8'h00;
  localparam logic [7:0] PORT_REMOTE = 8'ha0;
  localparam logic [7:0] PORT_TEST = 8'he0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned DEF_TRIES = 4;
  localparam int unsigned WAIT_SF7_S = 10;
  localparam int unsigned WAIT_SF8_S = 15;
  localparam int unsigned WAIT_SF9_S = 30;
  localparam int unsigned WAIT_SF10_S = 50;
  localparam int unsigned WAIT_SF11_S = 100;
  localparam int unsigned WAIT_SF12_S = 180;
  localparam int unsigned RAND_MAX_S = 4;
  localparam int unsigned PAUSE_MIN_MIN = 50;
  localparam int unsigned PAUSE_MAX_MIN = 70;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned SF_BASE = 7;
  localparam logic [2:0] SF_LAST_IDX = 3'd5;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND,
    ST_RESULT,
    ST_WAIT,
    ST_PAUSE,
    ST_JOINED
  } lpjc_state_t;

endpackage : lpjc_pkg

/* File: lpjc_lfsr.sv */
`timescale 1ns/1ps
module lpjc_lfsr (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic [31:0] rnd
);
  import lpjc_pkg::*;

  logic [31:0] state_ff;
  logic [31:0] nxt_state;

  // Galois generator; it steps every cycle so the value sampled by the
  // sequencer depends on the moment of the host's join request.
  always_comb begin
    nxt_state = {1'b0, state_ff[31:1]};
    if (state_ff[0]) begin
      nxt_state = nxt_state ^ 32'h80200003;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= 32'h00000001;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rnd = state_ff;

endmodule : lpjc_lfsr

/* File: lpjc_checker.sv */
`timescale 1ns/1ps
module lpjc_checker #(
  parameter int unsigned MS_CYCLES = 100000
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic join_start,
  input wire logic join_ok,
  input wire logic join_fail,
  input wire logic join_req,
  input wire logic [3:0] join_sf,
  input wire logic join_busy,
  input wire logic joined,
  input wire logic rx_win_eff,
  input wire logic adr_en,
  input wire logic adapt_rx2_en,
  input wire logic confirmed_sel,
  input wire logic [3:0] repeat_cnt,
  input wire logic repeat_default,
  input wire logic [7:0] frame_port,
  input wire logic port_mac_only,
  input wire logic port_remote,
  input wire logic port_test,
  input wire logic port_reserved,
  input wire logic fixed_dr_apply,
  input wire logic fixed_rx2_apply
);
  // Two cycles of slack cover the fail and request register stages.
  localparam longint unsigned MIN_GAP = 64'(MS_CYCLES) * 10000 - 2;
  logic [31:0] gap_ff;
  logic armed_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap_ff <= 32'h0;
      armed_ff <= 1'b0;
    end else begin
      gap_ff <= join_fail ? 32'h0 : gap_ff + {31'h0, ~&gap_ff};
      armed_ff <= (armed_ff | join_fail) & ~join_start;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_req_ok;
    join_req ##[1:8] join_ok;
  endsequence
  sequence s_fail_only;
    join_fail && !join_ok && join_busy;
  endsequence

  property p_adr_rx; adr_en |-> rx_win_eff; endproperty
  property p_conf_rx; confirmed_sel |-> rx_win_eff; endproperty
  property p_conf_prio;
    confirmed_sel |-> repeat_cnt != 4'h0 && !repeat_default;
  endproperty
  property p_port_cls;
    port_mac_only == (frame_port == 8'h00) &&
    port_remote == (frame_port == 8'ha0) &&
    port_test == (frame_port == 8'he0) &&
    port_reserved == (frame_port > 8'he0);
  endproperty
  property p_fix_dr; fixed_dr_apply != adr_en; endproperty
  property p_fix_rx2; fixed_rx2_apply != adapt_rx2_en; endproperty
  property p_sf_rng; join_req |-> join_sf >= 4'd7 && join_sf <= 4'd12;
  endproperty
  property p_gap; join_req && armed_ff |-> 64'(gap_ff) >= MIN_GAP;
  endproperty
  property p_fail_cont; s_fail_only |=> join_busy; endproperty
  property p_ok_join; s_req_ok |=> joined && !join_busy; endproperty
  property p_quiet; joined |-> !join_req && !join_busy; endproperty

  a_adr_rx: assert property (p_adr_rx) else $error("rx off with adr");
  a_conf_rx: assert property (p_conf_rx) else $error("rx off conf");
  a_conf_prio: assert property (p_conf_prio) else $error("prio");
  a_port_cls: assert property (p_port_cls) else $error("port cls");
  a_fix_dr: assert property (p_fix_dr) else $error("fixed dr");
  a_fix_rx2: assert property (p_fix_rx2) else $error("fixed rx2");
  a_sf_rng: assert property (p_sf_rng) else $error("sf range");
  a_gap: assert property (p_gap) else $error("retry too soon");
  a_fail_cont: assert property (p_fail_cont) else $error("abort");
  a_ok_join: assert property (p_ok_join) else $error("no join");
  a_quiet: assert property (p_quiet) else $error("req joined");
endmodule : lpjc_checker

bind lpjc_top lpjc_checker #(.MS_CYCLES(MS_CYCLES)) lpjc_checker_inst (
  .clk_sys, .nrst, .join_start, .join_ok, .join_fail, .join_req,
  .join_sf, .join_busy, .joined, .rx_win_eff, .adr_en, .adapt_rx2_en,
  .confirmed_sel, .repeat_cnt, .repeat_default, .frame_port,
  .port_mac_only, .port_remote, .port_test, .port_reserved,
  .fixed_dr_apply, .fixed_rx2_apply
);

/* File: lpjc_radio_model.sv */
`timescale 1ns/1ps
module lpjc_radio_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic join_req,
  input wire logic ans_ok,
  output logic join_ok,
  output logic join_fail
);
  logic [2:0] dly_ff;

  // The network answers each request three cycles later.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dly_ff <= 3'h0;
    end else begin
      dly_ff <= {dly_ff[1:0], join_req};
    end
  end
  assign join_ok = dly_ff[2] & ans_ok;
  assign join_fail = dly_ff[2] & ~ans_ok;
endmodule : lpjc_radio_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import lpjc_pkg::*;
  localparam int unsigned MS = 1;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic join_start = 1'b0;
  logic ans_ok = 1'b0;
  logic [7:0] cfg_rdata, frame_port;
  logic [3:0] join_sf, repeat_cnt;
  logic join_ok, join_fail, join_req, join_busy, joined, otaa_mode;
  logic rx_win_eff, adr_en, duty_en, adapt_chan_en, adapt_rx2_en;
  logic rx2_def_sf9, private_net, confirmed_sel, repeat_default;
  logic port_mac_only, port_remote, port_test, port_reserved;
  logic fixed_dr_apply, fixed_rx2_apply;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'h0bcc690a;

  always #5 clk_sys = ~clk_sys;

  lpjc_top #(.MS_CYCLES(MS)) lpjc_top_inst (
    .clk_sys, .nrst, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .join_start, .join_ok, .join_fail, .join_req, .join_sf, .join_busy,
    .joined, .otaa_mode, .rx_win_eff, .adr_en, .duty_en, .adapt_chan_en,
    .adapt_rx2_en, .rx2_def_sf9, .private_net, .confirmed_sel,
    .repeat_cnt, .repeat_default, .frame_port, .port_mac_only,
    .port_remote, .port_test, .port_reserved, .fixed_dr_apply,
    .fixed_rx2_apply
  );
  lpjc_radio_model lpjc_radio_model_inst (
    .clk_sys, .nrst, .join_req, .ans_ok, .join_ok, .join_fail
  );

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input string nm);
    @(posedge clk_sys);
    cfg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 chk(nm, e, cfg_rdata);
  endtask : rd

  task automatic pulse();
    @(posedge clk_sys);
    join_start <= 1'b1;
    @(posedge clk_sys);
    join_start <= 1'b0;
  endtask : pulse

  function automatic logic [7:0] sf_at(input logic [7:0] j, input int k);
    int t;
    int n;
    t = (j[3:0] == 4'h0) ? 4 : int'(j[3:0]);
    n = 0;
    sf_at = 8'h00;
    for (int s = 7; s <= 12; s++) begin
      if (s == 7 || s == 12 || j[(s - 4) % 8]) begin
        if (k >= n && k < n + t) sf_at = 8'(s);
        n += t;
      end
    end
  endfunction : sf_at

  task automatic cfg_check(input logic [7:0] e, p, b, j);
    logic [7:0] f;
    logic [7:0] q;
    wr(REG_EMIS_IDX, e);
    wr(REG_PORT_IDX, p);
    wr(REG_BEHAV_IDX, b);
    wr(REG_JOIN_IDX, j);
    rd(REG_EMIS_IDX, e, "emis");
    rd(REG_PORT_IDX, p, "port");
    rd(REG_BEHAV_IDX, b, "behav");
    rd(REG_JOIN_IDX, j, "join");
    f = {private_net, rx2_def_sf9, adapt_rx2_en, adapt_chan_en, duty_en,
         adr_en, otaa_mode, 1'b0};
    chk("feat", {b[7:2], b[0], 1'b0}, f);
    chk("rxwin", 8'(b[1] | b[2] | (|e[7:4])), 8'(rx_win_eff));
    q = (|e[7:4]) ? {4'h0, e[7:4]} : {4'h0, e[3:0]};
    q = q | {2'h0, |e[7:4], e == 8'h00, 4'h0};
    f = {2'h0, confirmed_sel, repeat_default, repeat_cnt};
    chk("rep", q, f);
    q = {4'h0, p == 8'h00, p == 8'ha0, p == 8'he0, p > 8'he0};
    f = {4'h0, port_mac_only, port_remote, port_test, port_reserved};
    chk("pcls", q, f);
    chk("fport", p, frame_port);
    f = 8'({fixed_dr_apply, fixed_rx2_apply});
    chk("fix", 8'({~b[2], ~b[5]}), f);
  endtask : cfg_check

  task automatic join_run(input logic [7:0] j, input int n,
                          input logic last_ok);
    int c;
    int lo;
    wr(REG_BEHAV_IDX, 8'h01);
    wr(REG_JOIN_IDX, j);
    pulse();
    // Every retry in these runs follows an attempt at the lowest factor.
    lo = int'(WAIT_SF7_S) * 1000 * MS;
    for (int k = 0; k < n; k++) begin
      c = 0;
      do begin
        @(posedge clk_sys);
        #1 c++;
      end while (join_req !== 1'b1 && c < 30000);
      if (c >= 30000) begin
        n_mismatch++;
        end_of_test();
      end
      ans_ok <= last_ok && (k == n - 1);
      chk("sf", sf_at(j, k), 8'(join_sf));
      if (k > 0) chk("gap", 8'h1, 8'(c >= lo && c <= lo + 4016));
    end
    repeat (6) @(posedge clk_sys);
    #1 chk("ok", {6'h0, last_ok, ~last_ok}, {6'h0, joined, join_busy});
  endtask : join_run

  initial begin
    logic [7:0] cs [6] = '{8'hf0, 8'h00, 8'ha0, 8'he0, 8'he1, 8'h0f};
    logic [31:0] r;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(REG_EMIS_IDX, EMIS_RST, "emis_rst");
    rd(REG_PORT_IDX, PORT_RST, "port_rst");
    rd(REG_BEHAV_IDX, BEHAV_RST, "behav_rst");
    rd(REG_JOIN_IDX, JOIN_RST, "join_rst");
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h00, "unmapped");
    rd(REG_EMIS_IDX, EMIS_RST, "emis_keep");
    for (int i = 0; i < 6; i++) begin
      cfg_check(cs[i], cs[i], cs[(i + 1) % 6], cs[(i + 2) % 6]);
    end
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      cfg_check(r[7:0], r[15:8], r[23:16], r[31:24]);
    end
    wr(REG_BEHAV_IDX, 8'h00);
    pulse();
    @(posedge clk_sys);
    #1 chk("abp", 8'h2, {6'h0, joined, join_busy});
    join_run(8'hf0, 5, 1'b1);
    join_run(8'h21, 2, 1'b1);
    // Both attempts fail: the sequencer parks in the long pause at SF7.
    join_run(8'h01, 2, 1'b0);
    rd(REG_STAT_IDX, 8'h04, "pause");
    end_of_test();
  end
endmodule : tb_top
